// ### core/usbf_hold_timer.sv
/*
  Counts cycles while a condition holds and pulses once when the
  count reaches its limit. Assumes run comes from sys_clk logic.
*/
`timescale 1ns/1ps
`default_nettype none
module usbf_hold_timer #(
  parameter int unsigned LIMIT = 625
) (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic run,
  output var  logic fire
);
  logic [31:0] cnt_reg;

  // Saturates so a long hold gives one pulse only
  always_ff @(posedge sys_clk) begin
    if (srst || !run) begin
      cnt_reg <= 32'h0000_0000;
    end else if (cnt_reg < LIMIT) begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fire <= 1'b0;
    end else begin
      fire <= run && (cnt_reg == LIMIT - 1);
    end
  end
endmodule
`default_nettype wire

// ### core/usbf_interrupt_flags.sv
/*
  USB interrupt and error flag block: sticky event and error flags,
  their enables, the error summary, the module interrupt request,
  line-state timers and the transaction status window, on APB.
  Assumes event pulses from the token engine on sys_clk and raw
  D+/D- levels from the transceiver.
*/
// Our own choices: the address map and the APB interface to the registers.
// Functional notes
// - Flags set by hardware, cleared writing one
// - Stall flag on stall handshake either role
// - Attach needs host, 2.5 us quiet, no SE0
// - Resume after 2.5 us continuous K state
// - Idle after 3 ms constant idle
// - Token done flag, endpoint info readable
// - Clearing token flag advances status FIFO
// - SOF flag: received token or host threshold
// - Error summary read-only, only enabled errors
// - Device role: bit 0 is bus reset
// - Host role: bit 0 is detach
// - Enable bit per flag, reset zero
// - Errors reach request only via enable bit 1
// - Bit stuff error flag
// - Bus matrix address error flag
// - DMA overflow, underflow or truncation flag
// - Turnaround timeout after 16 idle bit times
// - Data field not whole bytes flag
// - Data CRC16 failure flag
// - Host role: end-of-frame error on bit 1
// - Device role: token CRC5 error on bit 1
// - Packet identifier check failure flag
`timescale 1ns/1ps
`default_nettype none
module usbf_interrupt_flags
  import usbf_pkg::*;
#(
  parameter longint unsigned IDLE_CYCLES = IDLE_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              srst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  // Raw data lines
  input  wire logic              line_dp,
  input  wire logic              line_dm,
  // Token engine events
  input  wire logic              stall_evt,
  input  wire logic              token_done_evt,
  input  wire logic [STAT_W-1:0] token_status,
  output var  logic              token_ready,
  input  wire logic              sof_rx_evt,
  input  wire logic              sof_threshold_evt,
  input  wire logic              bus_reset_evt,
  input  wire logic              detach_evt,
  input  wire logic              eop_evt,
  input  wire logic              bit_stuff_evt,
  input  wire logic              bus_matrix_evt,
  input  wire logic              dma_evt,
  input  wire logic              field_size_evt,
  input  wire logic              data_crc_evt,
  input  wire logic              token_crc_evt,
  input  wire logic              frame_end_evt,
  input  wire logic              packet_id_evt,
  // Role and request
  output var  logic              host_role_enable,
  output var  logic              module_interrupt_request
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [FLAG_W-1:0] event_flags_reg;
  logic [FLAG_W-1:0] event_enable_reg;
  logic [FLAG_W-1:0] error_flags_reg;
  logic [FLAG_W-1:0] error_enable_reg;
  logic [FLAG_W-1:0] event_set;
  logic [FLAG_W-1:0] error_set;
  logic [FLAG_W-1:0] event_clr;
  logic [FLAG_W-1:0] error_clr;

  // ----------------------------------------------------------------
  // Line synchroniser and state decode
  // ----------------------------------------------------------------
  logic [1:0] line_meta_reg;
  logic [1:0] line_sync_reg;
  logic [1:0] line_prev_reg;
  logic       j_line;
  logic       k_line;
  logic       se0_line;
  logic       line_stable;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      line_meta_reg <= 2'h0;
      line_sync_reg <= 2'h0;
      line_prev_reg <= 2'h0;
    end else begin
      line_meta_reg <= {line_dp, line_dm};
      line_sync_reg <= line_meta_reg;
      line_prev_reg <= line_sync_reg;
    end
  end

  assign j_line      = (line_sync_reg == 2'h2);
  assign k_line      = (line_sync_reg == 2'h1);
  assign se0_line    = (line_sync_reg == 2'h0);
  assign line_stable = (line_sync_reg == line_prev_reg);

  // ----------------------------------------------------------------
  // Line timers
  // ----------------------------------------------------------------
  logic attach_fire;
  logic resume_fire;
  logic idle_fire;
  logic turn_fire;
  logic turn_armed_reg;

  // Quiet, non-SE0 bus while hosting
  usbf_hold_timer #(.LIMIT(QUIET_CYC)) u_attach_timer (
    .sys_clk (sys_clk),
    .srst    (srst),
    .run     (host_role_enable && !se0_line && line_stable),
    .fire    (attach_fire)
  );

  // Continuous K state
  usbf_hold_timer #(.LIMIT(QUIET_CYC)) u_resume_timer (
    .sys_clk (sys_clk),
    .srst    (srst),
    .run     (k_line),
    .fire    (resume_fire)
  );

  // Constant idle state
  usbf_hold_timer #(.LIMIT(32'(IDLE_CYCLES))) u_idle_timer (
    .sys_clk (sys_clk),
    .srst    (srst),
    .run     (j_line),
    .fire    (idle_fire)
  );

  // Idle bit times after end of packet
  usbf_hold_timer #(.LIMIT(TURN_CYC)) u_turn_timer (
    .sys_clk (sys_clk),
    .srst    (srst),
    .run     (turn_armed_reg && j_line),
    .fire    (turn_fire)
  );

  // Armed by EOP, dropped by new activity or a timeout
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      turn_armed_reg <= 1'b0;
    end else if (eop_evt) begin
      turn_armed_reg <= 1'b1;
    end else if (turn_fire || !j_line) begin
      turn_armed_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Status FIFO
  // ----------------------------------------------------------------
  logic [STAT_W-1:0]  stat_head;
  logic [FIFO_AW:0]   stat_count;
  logic               stat_full;
  logic               stat_pop;
  logic               token_set;

  usbf_stat_fifo u_stat_fifo (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .push      (token_done_evt && token_ready),
    .push_data (token_status),
    .pop       (stat_pop),
    .head      (stat_head),
    .count     (stat_count),
    .full      (stat_full)
  );

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      token_ready <= 1'b0;
    end else begin
      token_ready <= !stat_full && !(token_done_evt && stat_count == 3'(FIFO_DEPTH - 1));
    end
  end

  // Clearing the flag retires the head entry
  assign stat_pop  = event_clr[BIT_TOKEN] && event_flags_reg[BIT_TOKEN];
  // Next entry re-raises the flag at once
  assign token_set = (token_done_evt && token_ready) || (stat_pop && stat_count > 3'h1);

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic apb_setup;
  logic apb_write;
  logic mapped;

  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pready && pwrite && !pslverr;
  assign mapped    = (paddr == OFS_FLAGS) || (paddr == OFS_EN) || (paddr == OFS_ERR)
                  || (paddr == OFS_ERR_EN) || (paddr == OFS_STAT) || (paddr == OFS_CTRL);

  // One-cycle access phase, answered from the setup cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup && !mapped;
      prdata  <= 32'h0000_0000;
      if (apb_setup && !pwrite) begin
        case (paddr)
          OFS_FLAGS:  prdata <= {24'h00_0000, event_flags_reg};
          OFS_EN:     prdata <= {24'h00_0000, event_enable_reg};
          OFS_ERR:    prdata <= {24'h00_0000, error_flags_reg};
          OFS_ERR_EN: prdata <= {24'h00_0000, error_enable_reg};
          OFS_STAT:   prdata <= {24'h00_0000, stat_head, 2'h0};
          OFS_CTRL:   prdata <= {31'h0000_0000, host_role_enable};
          default:    prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Enables and control, all clear at reset
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      event_enable_reg <= FLAG_RST;
      error_enable_reg <= FLAG_RST;
      host_role_enable <= 1'b0;
    end else if (apb_write) begin
      if (paddr == OFS_EN) begin
        event_enable_reg <= pwdata[FLAG_W-1:0];
      end
      if (paddr == OFS_ERR_EN) begin
        error_enable_reg <= pwdata[FLAG_W-1:0];
      end
      if (paddr == OFS_CTRL) begin
        host_role_enable <= pwdata[CTRL_HOST];
      end
    end
  end

  // ----------------------------------------------------------------
  // Flag set sources
  // ----------------------------------------------------------------
  always_comb begin
    event_set              = '0;
    event_set[BIT_STALL]   = stall_evt;
    event_set[BIT_ATTACH]  = attach_fire;
    event_set[BIT_RESUME]  = resume_fire;
    event_set[BIT_IDLE]    = idle_fire;
    event_set[BIT_TOKEN]   = token_set;
    event_set[BIT_SOF]     = host_role_enable ? sof_threshold_evt : sof_rx_evt;
    event_set[BIT_RESET]   = host_role_enable ? detach_evt : bus_reset_evt;
    error_set              = '0;
    error_set[EBIT_STUFF]  = bit_stuff_evt;
    error_set[EBIT_MATRIX] = bus_matrix_evt;
    error_set[EBIT_DMA]    = dma_evt;
    error_set[EBIT_TURN]   = turn_fire;
    error_set[EBIT_FIELD]  = field_size_evt;
    error_set[EBIT_CRC16]  = data_crc_evt;
    error_set[EBIT_CRC5]   = host_role_enable ? frame_end_evt : token_crc_evt;
    error_set[EBIT_PID]    = packet_id_evt;
  end

  assign event_clr = (apb_write && paddr == OFS_FLAGS) ? pwdata[FLAG_W-1:0] : '0;
  assign error_clr = (apb_write && paddr == OFS_ERR) ? pwdata[FLAG_W-1:0] : '0;

  // ----------------------------------------------------------------
  // Sticky flags, set wins over write-one clear
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < FLAG_W; gi++) begin : g_flag
      if (gi == BIT_SUMMARY) begin : g_summary
        // Read-only, follows unmasked errors
        always_ff @(posedge sys_clk) begin
          if (srst) begin
            event_flags_reg[gi] <= 1'b0;
          end else begin
            event_flags_reg[gi] <= |(error_flags_reg & error_enable_reg);
          end
        end
      end else begin : g_event
        always_ff @(posedge sys_clk) begin
          if (srst) begin
            event_flags_reg[gi] <= 1'b0;
          end else if (event_set[gi]) begin
            event_flags_reg[gi] <= 1'b1;
          end else if (event_clr[gi]) begin
            event_flags_reg[gi] <= 1'b0;
          end
        end
      end
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          error_flags_reg[gi] <= 1'b0;
        end else if (error_set[gi]) begin
          error_flags_reg[gi] <= 1'b1;
        end else if (error_clr[gi]) begin
          error_flags_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Module interrupt request
  // ----------------------------------------------------------------
  // Errors pass only through the summary bit and its enable
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      module_interrupt_request <= 1'b0;
    end else begin
      module_interrupt_request <= |(event_flags_reg & event_enable_reg);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_w1c_clear: assert property (
    (apb_write && paddr == OFS_ERR && pwdata[EBIT_PID] && !packet_id_evt)
      |=> !error_flags_reg[EBIT_PID])
    else $error("error flag not cleared by write of one");

  a_stall_sticky: assert property (
    stall_evt |=> event_flags_reg[BIT_STALL]
      ##1 (event_flags_reg[BIT_STALL] || $past(event_clr[BIT_STALL])))
    else $error("stall flag not held after stall event");

  a_attach_host: assert property (
    $rose(event_flags_reg[BIT_ATTACH]) |-> $past(host_role_enable, 2))
    else $error("attach flag set outside host role");

  a_resume_kstate: assert property (
    $rose(event_flags_reg[BIT_RESUME]) |-> $past(k_line, 2) && $past(k_line, 8))
    else $error("resume flag without held K state");

  a_fifo_advance: assert property (
    (stat_pop && !(token_done_evt && token_ready)) |=> stat_count == $past(stat_count) - 3'h1)
    else $error("status FIFO did not advance on clear");

  a_summary_mask: assert property (
    (error_enable_reg == FLAG_RST) [*2] |-> !event_flags_reg[BIT_SUMMARY])
    else $error("summary set with all errors masked");

  a_reset_device: assert property (
    (!host_role_enable && bus_reset_evt) |=> event_flags_reg[BIT_RESET])
    else $error("bus reset flag not set in device role");

  a_detach_host: assert property (
    (host_role_enable && detach_evt) |=> event_flags_reg[BIT_RESET])
    else $error("detach flag not set in host role");

  a_err_gate: assert property (
    (!event_enable_reg[BIT_SUMMARY] && (event_flags_reg & event_enable_reg) == FLAG_RST)
      |=> !module_interrupt_request)
    else $error("request raised with error path disabled");

  a_eof_host: assert property (
    (host_role_enable && frame_end_evt) |=> error_flags_reg[EBIT_CRC5])
    else $error("end of frame error not flagged");

  a_request_raise: assert property (
    (event_flags_reg[BIT_STALL] && event_enable_reg[BIT_STALL]) |=> module_interrupt_request)
    else $error("request not raised for enabled flag");

  c_token_pop: cover property (stat_pop && stat_count > 3'h1);
  c_turn_timeout: cover property (turn_fire);
  c_error_request: cover property (event_flags_reg[BIT_SUMMARY] ##1 module_interrupt_request);
  c_apb_unmapped: cover property (pready && pslverr);

endmodule
`default_nettype wire

// ### core/usbf_pkg.sv
/*
  Shared constants for the USB interrupt flag block: register offsets,
  bit positions, status FIFO shape and line timing counts.
  Assumes a 250 MHz module clock and a full-speed bus.
*/
package usbf_pkg;

  // ----------------------------------------------------------------
  // Clock and line timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PS     = 4000;
  localparam int unsigned QUIET_NS   = 2500;
  localparam int unsigned QUIET_CYC  = (QUIET_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam longint unsigned IDLE_MS  = 3;
  localparam longint unsigned IDLE_CYC = (IDLE_MS * 64'd1_000_000_000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned BIT_PS     = 83333;
  localparam int unsigned TURN_BITS  = 16;
  localparam int unsigned TURN_CYC   = (TURN_BITS * BIT_PS) / CLK_PS + 1;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FLAGS  = 8'h00;
  localparam logic [7:0] OFS_EN     = 8'h04;
  localparam logic [7:0] OFS_ERR    = 8'h08;
  localparam logic [7:0] OFS_ERR_EN = 8'h0C;
  localparam logic [7:0] OFS_STAT   = 8'h10;
  localparam logic [7:0] OFS_CTRL   = 8'h14;

  localparam int unsigned FLAG_W = 8;
  localparam logic [FLAG_W-1:0] FLAG_RST = 8'h00;

  localparam int unsigned BIT_STALL   = 7;
  localparam int unsigned BIT_ATTACH  = 6;
  localparam int unsigned BIT_RESUME  = 5;
  localparam int unsigned BIT_IDLE    = 4;
  localparam int unsigned BIT_TOKEN   = 3;
  localparam int unsigned BIT_SOF     = 2;
  localparam int unsigned BIT_SUMMARY = 1;
  localparam int unsigned BIT_RESET   = 0;

  localparam int unsigned EBIT_STUFF  = 7;
  localparam int unsigned EBIT_MATRIX = 6;
  localparam int unsigned EBIT_DMA    = 5;
  localparam int unsigned EBIT_TURN   = 4;
  localparam int unsigned EBIT_FIELD  = 3;
  localparam int unsigned EBIT_CRC16  = 2;
  localparam int unsigned EBIT_CRC5   = 1;
  localparam int unsigned EBIT_PID    = 0;

  localparam int unsigned CTRL_HOST   = 0;

  // ----------------------------------------------------------------
  // Status FIFO: endpoint[5:2], direction[1], ping-pong[0]
  // ----------------------------------------------------------------
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned FIFO_AW    = 2;
  localparam int unsigned STAT_W     = 6;
  localparam int unsigned STAT_LSB   = 2;

endpackage

// ### core/usbf_stat_fifo.sv
/*
  Four-entry transaction status FIFO read through the status register.
  Assumes push is never offered while full.
*/
`timescale 1ns/1ps
`default_nettype none
module usbf_stat_fifo
  import usbf_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire logic              push,
  input  wire logic [STAT_W-1:0] push_data,
  input  wire logic              pop,
  output var  logic [STAT_W-1:0] head,
  output var  logic [FIFO_AW:0]  count,
  output var  logic              full
);
  logic [STAT_W-1:0]  mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wr_ptr_reg;
  logic [FIFO_AW-1:0] rd_ptr_reg;
  logic               do_push;
  logic               do_pop;

  assign do_push = push && !full;
  assign do_pop  = pop && (count != '0);
  assign head    = (count != '0) ? mem[rd_ptr_reg] : '0;
  assign full    = (count == FIFO_DEPTH[FIFO_AW:0]);

  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= push_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count      <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count <= count + {{FIFO_AW{1'b0}}, do_push} - {{FIFO_AW{1'b0}}, do_pop};
    end
  end
endmodule
`default_nettype wire

// ### sim/tb_usbf_interrupt_flags.sv
/*
  Self-checking bench for usbf_interrupt_flags: APB master tasks, one task per scenario.
  Assumes usbf_pkg and the line partner model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_usbf_interrupt_flags
  import usbf_pkg::*;
;
  logic              sys_clk, srst, psel, penable, pwrite, pready, pslverr;
  logic              tok_rdy, host, irq, slv;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, r;
  logic [14:0]       ev;
  logic [STAT_W-1:0] ts;
  logic [1:0]        ln;
  wire               dp, dm;
  int                error_cnt, n_tests, cyc;

  usbf_interrupt_flags #(.IDLE_CYCLES(50)) dut (
    .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_dp(dp), .line_dm(dm), .stall_evt(ev[0]), .token_done_evt(ev[1]),
    .token_status(ts), .token_ready(tok_rdy), .sof_rx_evt(ev[2]),
    .sof_threshold_evt(ev[3]), .bus_reset_evt(ev[4]), .detach_evt(ev[5]),
    .eop_evt(ev[6]), .bit_stuff_evt(ev[7]), .bus_matrix_evt(ev[8]), .dma_evt(ev[9]),
    .field_size_evt(ev[10]), .data_crc_evt(ev[11]), .token_crc_evt(ev[12]),
    .frame_end_evt(ev[13]), .packet_id_evt(ev[14]), .host_role_enable(host),
    .module_interrupt_request(irq));
  usbf_line_partner lp (.st(ln), .dp(dp), .dm(dm));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic pulse(input int i);
    @(posedge sys_clk);
    ev[i] <= 1'b1;
    @(posedge sys_clk);
    ev[i] <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(OFS_FLAGS);
    chk("flags rst", r, 32'h0000_0000);
    rd(OFS_EN);
    chk("enables rst", r, 32'h0000_0000);
    rd(OFS_ERR);
    chk("errors rst", r, 32'h0000_0000);
    rd(8'h40);
    chk("unmapped err", slv, 32'h0000_0001);
    chk("unmapped data", r, 32'h0000_0000);
  endtask
  task automatic t_stall;
    pulse(0);
    wt(3);
    chk("irq masked", irq, 32'h0000_0000);
    rd(OFS_FLAGS);
    chk("stall", r, 32'h0000_0080);
    wr(OFS_EN, 32'h0000_0080);
    rd(OFS_EN);
    chk("enable rw", r, 32'h0000_0080);
    chk("irq on", irq, 32'h0000_0001);
    wr(OFS_FLAGS, 32'h0000_0000);
    rd(OFS_FLAGS);
    chk("write zero", r, 32'h0000_0080);
    wr(OFS_FLAGS, 32'h0000_0080);
    rd(OFS_FLAGS);
    chk("w1c", r, 32'h0000_0000);
    chk("irq off", irq, 32'h0000_0000);
    wr(OFS_EN, 32'h0000_0000);
  endtask
  task automatic t_err;
    for (int i = 7; i < 15; i++) if (i != 13) pulse(i);
    rd(OFS_ERR);
    chk("errors", r, 32'h0000_00EF);
    rd(OFS_FLAGS);
    chk("summary masked", r, 32'h0000_0000);
    wr(OFS_ERR_EN, 32'h0000_0004);
    wt(3);
    rd(OFS_FLAGS);
    chk("summary set", r, 32'h0000_0002);
    chk("irq gated", irq, 32'h0000_0000);
    wr(OFS_EN, 32'h0000_0002);
    wt(3);
    chk("irq error", irq, 32'h0000_0001);
    wr(OFS_ERR, 32'h0000_00FF);
    wt(3);
    rd(OFS_ERR);
    chk("errors clr", r, 32'h0000_0000);
    chk("irq clr", irq, 32'h0000_0000);
    wr(OFS_EN, 32'h0000_0000);
    wr(OFS_ERR_EN, 32'h0000_0000);
  endtask
  task automatic t_token;
    ts <= 6'h2D;
    pulse(1);
    ts <= 6'h13;
    pulse(1);
    chk("token ready", tok_rdy, 32'h0000_0001);
    ts <= 6'h01;
    pulse(1);
    pulse(1);
    wt(1);
    chk("token full", tok_rdy, 32'h0000_0000);
    rd(OFS_FLAGS);
    chk("token flag", r, 32'h0000_0008);
    rd(OFS_STAT);
    chk("status 0", r, 32'h0000_00B4);
    wr(OFS_FLAGS, 32'h0000_0008);
    rd(OFS_STAT);
    chk("status 1", r, 32'h0000_004C);
    rd(OFS_FLAGS);
    chk("token again", r, 32'h0000_0008);
    wr(OFS_FLAGS, 32'h0000_0008);
    rd(OFS_STAT);
    chk("status 2", r, 32'h0000_0004);
    chk("token room", tok_rdy, 32'h0000_0001);
    wr(OFS_FLAGS, 32'h0000_0008);
    rd(OFS_FLAGS);
    chk("token last", r, 32'h0000_0008);
    wr(OFS_FLAGS, 32'h0000_0008);
    rd(OFS_FLAGS);
    chk("token empty", r, 32'h0000_0000);
  endtask
  task automatic t_role;
    pulse(4);
    pulse(2);
    rd(OFS_FLAGS);
    chk("device bits", r, 32'h0000_0005);
    wr(OFS_FLAGS, 32'h0000_0005);
    wr(OFS_CTRL, 32'h0000_0001);
    wt(1);
    chk("host role", host, 32'h0000_0001);
    pulse(5);
    pulse(3);
    pulse(13);
    rd(OFS_FLAGS);
    chk("host bits", r, 32'h0000_0005);
    rd(OFS_ERR);
    chk("frame end", r, 32'h0000_0002);
    wr(OFS_FLAGS, 32'h0000_0005);
    wr(OFS_ERR, 32'h0000_00FF);
    wr(OFS_CTRL, 32'h0000_0000);
  endtask
  task automatic t_line;
    // K state held 700 cycles sets the resume flag
    ln <= 2'h2;
    wt(700);
    rd(OFS_FLAGS);
    chk("resume", r, 32'h0000_0020);
    wr(OFS_FLAGS, 32'h0000_0020);
    ln <= 2'h1;
    wt(100);
    rd(OFS_FLAGS);
    chk("idle", r, 32'h0000_0010);
    wr(OFS_CTRL, 32'h0000_0001);
    wt(700);
    rd(OFS_FLAGS);
    chk("attach", r & 32'h0000_0040, 32'h0000_0040);
    pulse(6);
    wt(300);
    rd(OFS_ERR);
    chk("turn early", r, 32'h0000_0000);
    wt(100);
    rd(OFS_ERR);
    chk("turn late", r, 32'h0000_0010);
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog, main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    {srst, psel, penable, pwrite} = 4'h8;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ev = 15'h0000;
    ts = 6'h00;
    ln = 2'h0;
    {error_cnt, n_tests, cyc} = '0;
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    wt(2);
    t_reset();
    t_stall();
    t_err();
    t_token();
    t_role();
    t_line();
    conclude();
  end
endmodule
`default_nettype wire

// ### sim/usbf_line_partner.sv
/*
  Bus partner model: drives full-speed D+/D- levels for a chosen line state.
  Assumes the bench changes the state right after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module usbf_line_partner (
  input  wire logic [1:0] st,
  output var  logic       dp,
  output var  logic       dm
);
  // State codes: 0 SE0 (pull-downs), 1 J, 2 K
  always_comb begin
    dp = (st == 2'h1);
    dm = (st == 2'h2);
  end
endmodule
`default_nettype wire
